// ### design/hsl_gpio_ctrl.v
`timescale 1ns/10ps
`include "hsl_defines.vh"
module hsl_gpio_ctrl (
  // clock and reset
  input  wire       sys_clk_i,
  input  wire       rst_i,
  // local register access
  input  wire       loc_req_i,
  input  wire       loc_wr_i,
  input  wire [7:0] loc_addr_i,
  input  wire [7:0] loc_wdata_i,
  output wire [7:0] loc_rdata_o,
  output wire       loc_ack_o,
  // remote register access from the control channel
  input  wire       rem_req_i,
  input  wire       rem_wr_i,
  input  wire [7:0] rem_addr_i,
  input  wire [7:0] rem_wdata_i,
  output wire [7:0] rem_rdata_o,
  output wire       rem_ack_o,
  // forward link
  input  wire       link_clk_i,
  input  wire       link_two_lane_i,
  input  wire [3:0] fwd_gpio_i,
  input  wire [3:0] fwd_dgpio_i,
  input  wire       fwd_color18_i,
  output wire       color18_o,
  // strap
  input  wire       strap_mode_select_one_i,
  // standard linked pins
  input  wire [3:0] gpio_i,
  output wire [3:0] gpio_o,
  output wire [3:0] gpio_oe_o,
  // fast linked pins
  input  wire [3:0] dgpio_i,
  output wire [3:0] dgpio_o,
  output wire [3:0] dgpio_oe_o,
  // register-only pins five to eight
  input  wire [3:0] rgpio_i,
  output wire [3:0] rgpio_o,
  output wire [3:0] rgpio_oe_o,
  output wire [3:0] audio_din_o,
  // extra local pin
  input  wire       extra_local_io_nine_i,
  output wire       extra_local_io_nine_o,
  output wire       extra_local_io_nine_oe_o,
  // back channel
  output wire       bc_data_o,
  output wire       bc_bit_en_o
);
  // ========================================================
  // pin decode shared by the standard and fast groups; the register group uses drive_en only
  function drive_en;
    input [3:0] code;
    begin
      drive_en = (code == `HSL_CODE_OUT_LOW) ||
                 (code == `HSL_CODE_OUT_HIGH) ||
                 (code == `HSL_CODE_FWD_OUT);
    end
  endfunction

  function drive_val;
    input [3:0] code;
    input       fwd;
    begin
      if (code == `HSL_CODE_FWD_OUT) begin
        drive_val = fwd;
      end else begin
        drive_val = (code == `HSL_CODE_OUT_HIGH);
      end
    end
  endfunction

  // ========================================================
  // registers
  reg  [7:0] cfg9_q;
  reg  [7:0] l0_p0_q;
  reg  [7:0] l0_p1_q;
  reg  [7:0] l12_p0_q;
  reg  [7:0] l12_p1_q;
  reg  [7:0] l3_p0_q;
  reg  [7:0] l3_p1_q;
  reg  [7:0] r56_q;
  reg  [7:0] r78_q;
  reg  [7:0] rate_q;
  reg  [7:0] psel_q;
  reg  [7:0] fcc_q;
  reg        strap_done_q;
  reg  [7:0] rdata_q;
  reg        loc_ack_q;
  reg        rem_ack_q;
  reg  [7:0] rd_d;
  reg  [3:0] fwd_std_q;
  reg  [3:0] fwd_hs_q;
  reg        color18_q;
  reg        lclk_prev_q;
  reg  [3:0] gpio_q;
  reg  [3:0] gpio_oe_q;
  reg  [3:0] dgpio_q;
  reg  [3:0] dgpio_oe_q;
  reg  [3:0] rgpio_q;
  reg  [3:0] rgpio_oe_q;
  reg  [3:0] audio_q;
  reg        io9_q;
  reg        io9_oe_q;
  wire [10:0] link_s;
  wire [3:0] gpio_s;
  wire [3:0] dgpio_s;
  wire [3:0] rgpio_s;
  wire       io9_s;
  wire       strap_s;
  wire       two_lane;
  wire       lclk_s;
  wire       lclk_rise;
  wire [15:0] cfg_std;
  wire [15:0] cfg_hs;
  wire [15:0] cfg_reg;
  wire [3:0] bc_std;
  wire [3:0] bc_hs;
  wire       sel_loc;
  wire       acc;
  wire       acc_wr;
  wire [7:0] acc_addr;
  wire [7:0] acc_wdata;

  // ========================================================
  // input synchronisers
  hsl_sync #(.W(11)) u_link_sync (
    .clk_i (sys_clk_i),
    .d_i   ({link_clk_i, link_two_lane_i, fwd_color18_i,
             fwd_gpio_i, fwd_dgpio_i}),
    .q_o   (link_s)
  );

  hsl_sync #(.W(14)) u_pin_sync (
    .clk_i (sys_clk_i),
    .d_i   ({strap_mode_select_one_i, extra_local_io_nine_i,
             rgpio_i, dgpio_i, gpio_i}),
    .q_o   ({strap_s, io9_s, rgpio_s, dgpio_s, gpio_s})
  );

  assign lclk_s    = link_s[10];
  assign two_lane  = link_s[9];
  assign lclk_rise = lclk_s && !lclk_prev_q;

  // ========================================================
  // access arbitration: local wins, remote waits with req held
  assign sel_loc   = loc_req_i;
  assign acc       = loc_req_i || rem_req_i;
  assign acc_wr    = sel_loc ? loc_wr_i : rem_wr_i;
  assign acc_addr  = sel_loc ? loc_addr_i : rem_addr_i;
  assign acc_wdata = sel_loc ? loc_wdata_i : rem_wdata_i;

  // read mux; port copies return the second when both selected
  always @* begin
    rd_d = 8'h00;
    case (acc_addr)
      `HSL_A_EXTRA_LOCAL_IO_NINE_CFG:  rd_d = cfg9_q;
      `HSL_A_LINK0_CFG:
        rd_d = psel_q[`HSL_PSEL_SECOND_BIT] ? l0_p1_q : l0_p0_q;
      `HSL_A_LINK12_CFG:
        rd_d = psel_q[`HSL_PSEL_SECOND_BIT] ? l12_p1_q : l12_p0_q;
      `HSL_A_LINK3_CFG:
        rd_d = psel_q[`HSL_PSEL_SECOND_BIT] ? l3_p1_q : l3_p0_q;
      `HSL_A_REG56_CFG:  rd_d = r56_q;
      `HSL_A_REG78_CFG:  rd_d = r78_q;
      `HSL_A_BC_RATE:    rd_d = rate_q;
      `HSL_A_PORT_SEL:   rd_d = psel_q;
      `HSL_A_FCC_CFG:    rd_d = fcc_q;
      `HSL_A_IN_LOW:     rd_d = {rgpio_s[2:0], 1'b0, gpio_s};
      `HSL_A_IN_HIGH:    rd_d = {6'h00, io9_s, rgpio_s[3]};
      default:           rd_d = 8'h00;
    endcase
  end

  // register writes, strap capture and answers
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      cfg9_q       <= `HSL_REG_RESET;
      l0_p0_q      <= `HSL_REG_RESET;
      l0_p1_q      <= `HSL_REG_RESET;
      l12_p0_q     <= `HSL_REG_RESET;
      l12_p1_q     <= `HSL_REG_RESET;
      l3_p0_q      <= `HSL_REG_RESET;
      l3_p1_q      <= `HSL_REG_RESET;
      r56_q        <= `HSL_REG_RESET;
      r78_q        <= `HSL_REG_RESET;
      rate_q       <= `HSL_REG_RESET;
      psel_q       <= `HSL_REG_RESET;
      fcc_q        <= `HSL_REG_RESET;
      strap_done_q <= 1'b0;
      rdata_q      <= 8'h00;
      loc_ack_q    <= 1'b0;
      rem_ack_q    <= 1'b0;
    end else begin
      loc_ack_q <= loc_req_i;
      rem_ack_q <= rem_req_i && !loc_req_i;
      if (acc) begin
        rdata_q <= acc_wr ? 8'h00 : rd_d;
      end
      // strap loads the fast bit once, after reset release
      if (!strap_done_q) begin
        strap_done_q <= 1'b1;
        rate_q[`HSL_FAST_BC_BIT] <= strap_s;
      end
      if (acc && acc_wr) begin
        case (acc_addr)
          `HSL_A_EXTRA_LOCAL_IO_NINE_CFG: cfg9_q <= acc_wdata;
          `HSL_A_LINK0_CFG: begin
            if (psel_q[`HSL_PSEL_FIRST_BIT]) l0_p0_q <= acc_wdata;
            if (psel_q[`HSL_PSEL_SECOND_BIT]) l0_p1_q <= acc_wdata;
          end
          `HSL_A_LINK12_CFG: begin
            if (psel_q[`HSL_PSEL_FIRST_BIT]) l12_p0_q <= acc_wdata;
            if (psel_q[`HSL_PSEL_SECOND_BIT]) l12_p1_q <= acc_wdata;
          end
          `HSL_A_LINK3_CFG: begin
            if (psel_q[`HSL_PSEL_FIRST_BIT]) l3_p0_q <= acc_wdata;
            if (psel_q[`HSL_PSEL_SECOND_BIT]) l3_p1_q <= acc_wdata;
          end
          `HSL_A_REG56_CFG: r56_q  <= acc_wdata;
          `HSL_A_REG78_CFG: r78_q  <= acc_wdata;
          `HSL_A_BC_RATE:   rate_q <= acc_wdata;
          `HSL_A_PORT_SEL:  psel_q <= acc_wdata;
          `HSL_A_FCC_CFG:   fcc_q  <= acc_wdata;
          default: ;
        endcase
      end
    end
  end

  // ========================================================
  // forward link samples, taken on each link clock rise
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      lclk_prev_q <= 1'b0;
      fwd_std_q   <= 4'h0;
      fwd_hs_q    <= 4'h0;
      color18_q   <= 1'b0;
    end else begin
      lclk_prev_q <= lclk_s;
      if (lclk_rise) begin
        fwd_std_q <= link_s[7:4];
        fwd_hs_q  <= link_s[3:0];
        color18_q <= link_s[8];
      end
    end
  end

  // ========================================================
  // field layout: port copy 0 drives standard, copy 1 fast pins
  assign cfg_std = {l3_p0_q[3:0], l12_p0_q[7:4], l12_p0_q[3:0],
                    l0_p0_q[3:0]};
  assign cfg_hs  = {l3_p1_q[3:0], l12_p1_q[7:4], l12_p1_q[3:0],
                    l0_p1_q[3:0]};
  assign cfg_reg = {r78_q, r56_q};

  // per-pin drivers and back channel bits
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
      assign bc_std[gi] = (cfg_std[gi*4 +: 4] == `HSL_CODE_INPUT) &&
                          gpio_s[gi];
      assign bc_hs[gi]  = (cfg_hs[gi*4 +: 4] == `HSL_CODE_INPUT) &&
                          two_lane && dgpio_s[gi];

      always @(posedge sys_clk_i) begin
        if (rst_i) begin
          gpio_q[gi]     <= 1'b0;
          gpio_oe_q[gi]  <= 1'b0;
          dgpio_q[gi]    <= 1'b0;
          dgpio_oe_q[gi] <= 1'b0;
          rgpio_q[gi]    <= 1'b0;
          rgpio_oe_q[gi] <= 1'b0;
          audio_q[gi]    <= 1'b0;
        end else begin
          gpio_oe_q[gi] <= drive_en(cfg_std[gi*4 +: 4]);
          gpio_q[gi]    <= drive_val(cfg_std[gi*4 +: 4], fwd_std_q[gi]);
          // fast pins are dead outside two-lane operation
          dgpio_oe_q[gi] <= two_lane && drive_en(cfg_hs[gi*4 +: 4]);
          dgpio_q[gi]    <= two_lane &&
                            drive_val(cfg_hs[gi*4 +: 4], fwd_hs_q[gi]);
          // no forwarded data reaches the register pins
          rgpio_oe_q[gi] <= drive_en(cfg_reg[gi*4 +: 4]) &&
                            (cfg_reg[gi*4 +: 4] != `HSL_CODE_FWD_OUT);
          rgpio_q[gi]    <= (cfg_reg[gi*4 +: 4] == `HSL_CODE_OUT_HIGH);
          // pin mode takes the pin away from the audio input
          audio_q[gi] <= (cfg_reg[gi*4 +: 4] == `HSL_CODE_OUT_LOW ||
                          cfg_reg[gi*4 +: 4] == `HSL_CODE_OUT_HIGH ||
                          cfg_reg[gi*4 +: 4] == `HSL_CODE_INPUT) ?
                         1'b0 : rgpio_s[gi];
        end
      end
    end
  endgenerate

  // extra local pin, low or high only
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      io9_q    <= 1'b0;
      io9_oe_q <= 1'b0;
    end else begin
      io9_oe_q <= (cfg9_q[3:0] == `HSL_CODE_OUT_LOW) ||
                  (cfg9_q[3:0] == `HSL_CODE_OUT_HIGH);
      io9_q    <= (cfg9_q[3:0] == `HSL_CODE_OUT_HIGH);
    end
  end

  // ========================================================
  // back channel sender
  hsl_bc_tx u_bc_tx (
    .sys_clk_i   (sys_clk_i),
    .rst_i       (rst_i),
    .fast_en_i   (rate_q[`HSL_FAST_BC_BIT]),
    .rate_sel_i  (rate_q[`HSL_RATE_SEL_BIT]),
    .mode_i      (fcc_q[2:0]),
    .std_bits_i  (bc_std),
    .hs_bits_i   (bc_hs),
    .bc_data_o   (bc_data_o),
    .bc_bit_en_o (bc_bit_en_o)
  );

  assign loc_rdata_o              = rdata_q;
  assign loc_ack_o                = loc_ack_q;
  assign rem_rdata_o              = rdata_q;
  assign rem_ack_o                = rem_ack_q;
  assign color18_o                = color18_q;
  assign gpio_o                   = gpio_q;
  assign gpio_oe_o                = gpio_oe_q;
  assign dgpio_o                  = dgpio_q;
  assign dgpio_oe_o               = dgpio_oe_q;
  assign rgpio_o                  = rgpio_q;
  assign rgpio_oe_o               = rgpio_oe_q;
  assign audio_din_o              = audio_q;
  assign extra_local_io_nine_o    = io9_q;
  assign extra_local_io_nine_oe_o = io9_oe_q;
endmodule // hsl_gpio_ctrl

// ### design/hsl_defines.vh
`ifndef HSL_DEFINES_VH
`define HSL_DEFINES_VH

// ==========================================================
// register offsets
`define HSL_A_EXTRA_LOCAL_IO_NINE_CFG     8'h1A
`define HSL_A_LINK0_CFG     8'h1D
`define HSL_A_LINK12_CFG    8'h1E
`define HSL_A_LINK3_CFG     8'h1F
`define HSL_A_REG56_CFG     8'h20
`define HSL_A_REG78_CFG     8'h21
`define HSL_A_BC_RATE       8'h23
`define HSL_A_PORT_SEL      8'h34
`define HSL_A_FCC_CFG       8'h43
`define HSL_A_IN_LOW        8'h6E
`define HSL_A_IN_HIGH       8'h6F

// ==========================================================
// reset value of every writable register
`define HSL_REG_RESET       8'h00

// ==========================================================
// field positions
`define HSL_RATE_SEL_BIT    6
`define HSL_FAST_BC_BIT     4
`define HSL_PSEL_FIRST_BIT  0
`define HSL_PSEL_SECOND_BIT 1

// ==========================================================
// 4-bit pin configuration codes
`define HSL_CODE_OUT_LOW    4'h1
`define HSL_CODE_INPUT      4'h3
`define HSL_CODE_FWD_OUT    4'h5
`define HSL_CODE_OUT_HIGH   4'h9

// ==========================================================
// fast control channel modes
`define HSL_MODE_NORMAL4    3'h0
`define HSL_MODE_FAST1      3'h1
`define HSL_MODE_FAST2      3'h2
`define HSL_MODE_FAST4      3'h3

// ==========================================================
// back channel timing: oscillator dividers and frame shape
`define HSL_DIV_SLOW        2'h3
`define HSL_DIV_MID         2'h1
`define HSL_DIV_FAST        2'h0
`define HSL_FRAME_LAST      5'h1D
`define HSL_SPACE_NORMAL4   5'h1D
`define HSL_SPACE_FAST4     5'h04
`define HSL_SPACE_FAST2     5'h02
`define HSL_SPACE_FAST1     5'h01

`endif

// ### design/hsl_sync.v
`timescale 1ns/10ps
// ==========================================================
// two-flop synchroniser, no reset so straps settle during reset
module hsl_sync #(
  parameter W = 1
) (
  // clock
  input  wire         clk_i,
  // data
  input  wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // first stage feeds only the second stage
  always @(posedge clk_i) begin
    meta_q <= d_i;
    sync_q <= meta_q;
  end

  assign q_o = sync_q;
endmodule // hsl_sync

// ### design/hsl_bc_tx.v
`timescale 1ns/10ps
`include "hsl_defines.vh"
// ==========================================================
// back channel frame sender: rate divider, sampler, shifter
module hsl_bc_tx (
  // clock and reset
  input  wire       sys_clk_i,
  input  wire       rst_i,
  // configuration
  input  wire       fast_en_i,
  input  wire       rate_sel_i,
  input  wire [2:0] mode_i,
  // sampled pin levels
  input  wire [3:0] std_bits_i,
  input  wire [3:0] hs_bits_i,
  // serial back channel
  output wire       bc_data_o,
  output wire       bc_bit_en_o
);
  reg  [1:0]  div_q;
  reg  [4:0]  pos_q;
  reg  [4:0]  scnt_q;
  reg  [23:0] samp_q;
  reg  [29:0] shreg_q;
  reg         data_q;
  reg         bit_en_q;
  reg  [1:0]  div_lim;
  reg  [4:0]  space;
  reg  [23:0] samp_d;
  wire        tick;
  wire        take;
  wire        last;

  // divider choice; the fast bit overrides the rate bit
  always @* begin
    if (fast_en_i) begin
      div_lim = `HSL_DIV_FAST;
    end else if (rate_sel_i) begin
      div_lim = `HSL_DIV_MID;
    end else begin
      div_lim = `HSL_DIV_SLOW;
    end
  end

  // sample spacing in bit times; 30-bit frame gives 1/6/10/15
  always @* begin
    case (mode_i)
      `HSL_MODE_NORMAL4: space = `HSL_SPACE_NORMAL4;
      `HSL_MODE_FAST4:   space = `HSL_SPACE_FAST4;
      `HSL_MODE_FAST2:   space = `HSL_SPACE_FAST2;
      `HSL_MODE_FAST1:   space = `HSL_SPACE_FAST1;
      default:           space = `HSL_SPACE_NORMAL4;
    endcase
  end

  assign tick = (div_q == div_lim);
  assign last = (pos_q == `HSL_FRAME_LAST);
  assign take = tick && (scnt_q == space);

  // new sample word; unused modes carry no samples
  always @* begin
    samp_d = samp_q;
    if (take) begin
      case (mode_i)
        `HSL_MODE_NORMAL4: samp_d = {samp_q[19:0], hs_bits_i};
        `HSL_MODE_FAST4:   samp_d = {samp_q[19:0], hs_bits_i};
        `HSL_MODE_FAST2:   samp_d = {samp_q[21:0], hs_bits_i[1:0]};
        `HSL_MODE_FAST1:   samp_d = {samp_q[22:0], hs_bits_i[0]};
        default:           samp_d = 24'h000000;
      endcase
    end
  end

  // divider, bit position, sampler and frame shifter
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      div_q    <= 2'h0;
      pos_q    <= 5'h00;
      scnt_q   <= 5'h00;
      samp_q   <= 24'h000000;
      shreg_q  <= 30'h00000000;
      data_q   <= 1'b0;
      bit_en_q <= 1'b0;
    end else begin
      bit_en_q <= tick;
      div_q    <= tick ? 2'h0 : div_q + 2'h1;
      if (tick) begin
        data_q <= shreg_q[29];
        pos_q  <= last ? 5'h00 : pos_q + 5'h01;
        scnt_q <= (take || last) ? 5'h00 : scnt_q + 5'h01;
        samp_q <= samp_d;
        // idle, start, four standard bits, sample payload
        if (last) begin
          shreg_q <= {1'b0, 1'b1, std_bits_i, samp_d};
        end else begin
          shreg_q <= {shreg_q[28:0], 1'b0};
        end
      end
    end
  end

  assign bc_data_o   = data_q;
  assign bc_bit_en_o = bit_en_q;
endmodule // hsl_bc_tx

// ### sim/hsl_gpio_ctrl_checker.sv
`timescale 1ns/10ps
// ==========================================
// port-level checks beside the gpio controller
module hsl_gpio_checker (
  // clock and reset
  input wire       sys_clk_i,
  input wire       rst_i,
  // register access
  input wire       loc_req_i,
  input wire       loc_ack_o,
  input wire       rem_req_i,
  input wire       rem_ack_o,
  input wire [7:0] loc_rdata_o,
  // link and pins
  input wire       link_two_lane_i,
  input wire       fwd_color18_i,
  input wire       color18_o,
  input wire [3:0] dgpio_o,
  input wire [3:0] rgpio_oe_o,
  input wire [3:0] audio_din_o,
  input wire       bc_data_o,
  input wire       bc_bit_en_o
);
  // one clock domain, reset gates every check
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  a_loc_ack_next: assert property (loc_req_i |=> loc_ack_o)
    else $error("local access not acknowledged");
  a_ack_has_cause: assert property (loc_ack_o |-> $past(loc_req_i))
    else $error("local ack without request");
  a_remote_refused: assert property (
    loc_req_i && rem_req_i |=> !rem_ack_o)
    else $error("remote ack during local access");
  a_remote_taken: assert property (
    rem_req_i && !loc_req_i |=> rem_ack_o)
    else $error("remote access not acknowledged");
  a_rdata_holds: assert property (
    $changed(loc_rdata_o) |-> loc_ack_o || rem_ack_o)
    else $error("read data moved without ack");
  a_one_lane_quiet: assert property (
    (!link_two_lane_i) [*4] |-> dgpio_o == 4'h0)
    else $error("fast pins active on one lane");
  a_bc_bit_timing: assert property (
    $changed(bc_data_o) |-> bc_bit_en_o)
    else $error("back channel bit moved off its strobe");
  a_audio_override: assert property (
    (rgpio_oe_o & audio_din_o) == 4'h0)
    else $error("audio input passed on a gpio pin");
  a_colour_follow: assert property (
    $rose(fwd_color18_i) |-> ##[1:24] color18_o)
    else $error("colour depth not adopted");
  c_refused: cover property (loc_req_i && rem_req_i);
  c_fast_bits: cover property (bc_bit_en_o ##1 bc_bit_en_o);
  c_colour: cover property ($rose(color18_o));
endmodule // hsl_gpio_checker

bind hsl_gpio_ctrl hsl_gpio_checker u_chk (.sys_clk_i, .rst_i,
  .loc_req_i, .loc_ack_o, .rem_req_i, .rem_ack_o, .loc_rdata_o,
  .link_two_lane_i, .fwd_color18_i, .color18_o, .dgpio_o,
  .rgpio_oe_o, .audio_din_o, .bc_data_o, .bc_bit_en_o);

// ### sim/hsl_ser_model.sv
`timescale 1ns/10ps
// ==========================================
// paired serializer: forward samples out, back channel in
module hsl_ser_model (
  // forward link
  output reg        link_clk_o,
  output reg [3:0]  fwd_gpio_o,
  output reg [3:0]  fwd_dgpio_o,
  output reg        fwd_color18_o,
  // values the bench wants forwarded
  input  wire [3:0] gpio_set_i,
  input  wire [3:0] dgpio_set_i,
  input  wire       color18_set_i,
  // back channel capture
  input  wire       sys_clk_i,
  input  wire       bc_data_i,
  input  wire       bc_bit_en_i,
  output reg [29:0] bc_bits_o
);
  // link clock free running, odd offset keeps it unrelated in phase
  initial begin
    link_clk_o = 1'b0;
    fwd_gpio_o = 4'h0;
    fwd_dgpio_o = 4'h0;
    fwd_color18_o = 1'b0;
    bc_bits_o = 30'h0;
    #7;
    forever #80 link_clk_o = ~link_clk_o;
  end
  // launch on the fall so samples are steady at the rise
  always @(negedge link_clk_o) begin
    fwd_gpio_o <= gpio_set_i;
    fwd_dgpio_o <= dgpio_set_i;
    fwd_color18_o <= color18_set_i;
  end
  // keep the last frame's worth of back channel bits
  always @(posedge sys_clk_i) begin
    if (bc_bit_en_i) bc_bits_o <= {bc_bits_o[28:0], bc_data_i};
  end
endmodule // hsl_ser_model

// ### sim/hsl_gpio_ctrl_tb.sv
`timescale 1ns/10ps
`include "hsl_defines.vh"
module hsl_gpio_ctrl_tb;
  // ==========================================
  // stimulus and observed signals
  reg        sys_clk_i;
  reg        rst_i = 1'b1;
  reg        loc_req = 0, loc_wr = 0, rem_req = 0, rem_wr = 0;
  reg  [7:0] loc_addr = 0, loc_wd = 0, rem_addr = 0, rem_wd = 0, rd;
  reg        two_lane = 0, strap = 0, nine_in = 0, cset = 0;
  reg  [3:0] gpio_in = 0, dgpio_in = 0, rgpio_in = 0, gset = 0, dset = 0;
  wire [7:0] loc_rdata, rem_rdata;
  wire       loc_ack, rem_ack, link_clk, fwd_c, color18;
  wire [3:0] fwd_g, fwd_d, gpio_o, gpio_oe, dgpio_o, dgpio_oe;
  wire [3:0] rgpio_o, rgpio_oe, audio;
  wire       nine_o, nine_oe, bc_data, bc_en;
  wire [29:0] bc_bits;
  integer    bad_count = 0, n_checks = 0, cyc = 0, i, k, c;
  reg  [3:0] cd;
  // pin tables: config offset, upper nibble, status bit
  localparam [71:0] CA = {8'h1A, 8'h21, 8'h21, 8'h20, 8'h20, 8'h1F,
                          8'h1E, 8'h1E, 8'h1D};
  localparam [8:0]  SH4 = 9'h0A4;
  localparam [26:0] RB = {3'h1, 3'h0, 3'h7, 3'h6, 3'h5, 3'h3, 3'h2,
                          3'h1, 3'h0};
  localparam [95:0] RA = {8'h55, 8'h6F, 8'h6E, 8'h43, 8'h34, 8'h23,
                          8'h21, 8'h20, 8'h1F, 8'h1E, 8'h1D, 8'h1A};
  localparam [39:0] PL = {8'h11, 8'hFF, 8'h55, 8'h11, 8'h00};
  // wire level of each shared pin from both drivers
  wire [3:0] gw = (gpio_oe & gpio_o) | (~gpio_oe & gpio_in);
  wire [3:0] dw = (dgpio_oe & dgpio_o) | (~dgpio_oe & dgpio_in);
  wire [3:0] rw = (rgpio_oe & rgpio_o) | (~rgpio_oe & rgpio_in);
  wire       nw = nine_oe ? nine_o : nine_in;

  hsl_gpio_ctrl dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .loc_req_i(loc_req), .loc_wr_i(loc_wr), .loc_addr_i(loc_addr),
    .loc_wdata_i(loc_wd), .loc_rdata_o(loc_rdata), .loc_ack_o(loc_ack),
    .rem_req_i(rem_req), .rem_wr_i(rem_wr), .rem_addr_i(rem_addr),
    .rem_wdata_i(rem_wd), .rem_rdata_o(rem_rdata), .rem_ack_o(rem_ack),
    .link_clk_i(link_clk), .link_two_lane_i(two_lane),
    .fwd_gpio_i(fwd_g), .fwd_dgpio_i(fwd_d), .fwd_color18_i(fwd_c),
    .color18_o(color18), .strap_mode_select_one_i(strap),
    .gpio_i(gw), .gpio_o(gpio_o), .gpio_oe_o(gpio_oe),
    .dgpio_i(dw), .dgpio_o(dgpio_o), .dgpio_oe_o(dgpio_oe),
    .rgpio_i(rw), .rgpio_o(rgpio_o), .rgpio_oe_o(rgpio_oe),
    .audio_din_o(audio), .extra_local_io_nine_i(nw),
    .extra_local_io_nine_o(nine_o), .extra_local_io_nine_oe_o(nine_oe),
    .bc_data_o(bc_data), .bc_bit_en_o(bc_en));
  hsl_ser_model u_ser (.link_clk_o(link_clk), .fwd_gpio_o(fwd_g),
    .fwd_dgpio_o(fwd_d), .fwd_color18_o(fwd_c), .gpio_set_i(gset),
    .dgpio_set_i(dset), .color18_set_i(cset), .sys_clk_i(sys_clk_i),
    .bc_data_i(bc_data), .bc_bit_en_i(bc_en), .bc_bits_o(bc_bits));

  // ==========================================
  // clock and hang guard
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      summarize;
    end
  end

  // ==========================================
  // shared tasks
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // one access, request dropped at the taking edge
  task acc(input r, input w, input [7:0] a, input [7:0] d);
    begin
      @(posedge sys_clk_i);
      loc_req <= !r; rem_req <= r; loc_wr <= w; rem_wr <= w;
      loc_addr <= a; rem_addr <= a; loc_wd <= d; rem_wd <= d;
      @(posedge sys_clk_i);
      loc_req <= 1'b0; rem_req <= 1'b0;
      #1;
      chk({7'h0, r ? rem_ack : loc_ack}, 8'h01);
      rd = r ? rem_rdata : loc_rdata;
    end
  endtask
  task gap(input [7:0] exp);
    integer n;
    begin
      repeat (8) @(posedge sys_clk_i);
      for (n = 0; bc_en !== 1'b1 && n < 20; n = n + 1) @(posedge sys_clk_i);
      n = 0;
      do begin
        @(posedge sys_clk_i);
        n = n + 1;
      end while (bc_en !== 1'b1 && n < 20);
      chk(n[7:0], exp);
    end
  endtask
  // captured bits are a rotation of the expected frame
  task frame_chk(input [23:0] p);
    integer r;
    reg [59:0] t;
    reg hit;
    begin
      repeat (900) @(posedge sys_clk_i);
      hit = 1'b0;
      for (r = 0; r < 30; r = r + 1) begin
        t = {bc_bits, bc_bits} >> r;
        if (t[29:0] == {2'h1, 4'h1, p}) hit = 1'b1;
      end
      chk({7'h0, hit}, 8'h01);
    end
  endtask
  task wait_pins(input [1:0] e);
    begin
      for (i = 0; i < 40 && {dgpio_o[0], gpio_o[0]} !== e; i = i + 1) begin
        @(posedge sys_clk_i);
        #1;
      end
      chk({6'h0, dgpio_o[0], gpio_o[0]}, {6'h0, e});
    end
  endtask
  function [1:0] pin(input integer p);
    if (p < 4) pin = {gpio_oe[p], gpio_o[p]};
    else if (p < 8) pin = {rgpio_oe[p-4], rgpio_o[p-4]};
    else pin = {nine_oe, nine_o};
  endfunction
  task summarize;
    begin
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask

  // ==========================================
  // main sequence
  initial begin
    repeat (20) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 12; i = i + 1) begin
      acc(i[0], 1'b0, RA[i*8 +: 8], 8'h00);
      chk(rd, `HSL_REG_RESET);
    end
    acc(1'b0, 1'b1, `HSL_A_IN_LOW, 8'hFF);
    acc(1'b1, 1'b0, `HSL_A_IN_LOW, 8'h00);
    chk(rd, 8'h00);
    // two copies behind one offset
    @(posedge sys_clk_i);
    two_lane <= 1'b1;
    acc(1'b0, 1'b1, `HSL_A_PORT_SEL, 8'h02);
    acc(1'b1, 1'b1, `HSL_A_LINK0_CFG, 8'h01);
    acc(1'b0, 1'b1, `HSL_A_PORT_SEL, 8'h01);
    acc(1'b0, 1'b1, `HSL_A_LINK0_CFG, 8'h09);
    acc(1'b0, 1'b1, `HSL_A_PORT_SEL, 8'h03);
    acc(1'b1, 1'b0, `HSL_A_LINK0_CFG, 8'h00);
    chk(rd, 8'h01);
    chk({4'h0, gpio_oe[0], gpio_o[0], dgpio_oe[0], dgpio_o[0]}, 8'h0E);
    // local wins a collision, remote waits with request held
    @(posedge sys_clk_i);
    loc_req <= 1'b1; loc_wr <= 1'b0; loc_addr <= `HSL_A_PORT_SEL;
    rem_req <= 1'b1; rem_wr <= 1'b0; rem_addr <= `HSL_A_LINK0_CFG;
    @(posedge sys_clk_i);
    loc_req <= 1'b0;
    #1;
    chk({6'h0, loc_ack, rem_ack}, 8'h02);
    @(posedge sys_clk_i);
    rem_req <= 1'b0;
    #1;
    chk({6'h0, loc_ack, rem_ack}, 8'h01);
    chk(rem_rdata, 8'h01);
    // both copies forward link data; write lands in each
    acc(1'b0, 1'b1, `HSL_A_LINK0_CFG, 8'h05);
    @(posedge sys_clk_i);
    gset <= 4'hF; dset <= 4'hF; cset <= 1'b1;
    wait_pins(2'h3);
    chk({7'h0, color18}, 8'h01);
    @(posedge sys_clk_i);
    gset <= 4'h0;
    wait_pins(2'h2);
    repeat (30) @(posedge sys_clk_i);
    chk({6'h0, pin(0)}, 8'h02);
    @(posedge sys_clk_i);
    two_lane <= 1'b0;
    repeat (8) @(posedge sys_clk_i);
    chk({4'h0, dgpio_o}, 8'h00);
    // every local pin through low, high and input codes
    @(posedge sys_clk_i);
    gpio_in <= 4'hF; rgpio_in <= 4'hF; nine_in <= 1'b1;
    acc(1'b0, 1'b1, `HSL_A_PORT_SEL, 8'h01);
    for (k = 0; k < 9; k = k + 1) for (c = 0; c < 4; c = c + 1) begin
      cd = c == 0 ? `HSL_CODE_OUT_LOW : c == 1 ? `HSL_CODE_OUT_HIGH
         : c == 2 ? `HSL_CODE_INPUT : `HSL_CODE_FWD_OUT;
      acc(c == 1, 1'b1, CA[k*8 +: 8], SH4[k] ? {cd, 4'h0} : {4'h0, cd});
      @(posedge sys_clk_i);
      #1;
      chk({6'h0, pin(k)}, c == 0 || c == 3 && k < 4 ? 8'h02
          : c == 1 ? 8'h03 : 8'h00);
      if (k > 3 && k < 8) chk({7'h0, audio[k-4]}, {7'h0, c == 3});
      repeat (3) @(posedge sys_clk_i);
      acc(c == 2, 1'b0, k > 6 ? 8'h6F : 8'h6E, 8'h00);
      chk({7'h0, rd[RB[k*3 +: 3]]},
          {7'h0, c != 0 && (c < 3 || k > 3)});
    end
    // back channel rates; slow rate first, as for older partners
    for (k = 0; k < 4; k = k + 1) begin
      acc(1'b0, 1'b1, `HSL_A_BC_RATE, k == 0 ? 8'h00 : k == 1 ? 8'h40
          : k == 2 ? 8'h10 : 8'h50);
      gap(k == 0 ? 8'h04 : k == 1 ? 8'h02 : 8'h01);
    end
    // second reset with the fast strap fitted
    @(posedge sys_clk_i);
    strap <= 1'b1; rst_i <= 1'b1;
    repeat (20) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    acc(1'b0, 1'b0, `HSL_A_BC_RATE, 8'h00);
    chk(rd, 8'h10);
    gap(8'h01);
    acc(1'b0, 1'b1, `HSL_A_BC_RATE, 8'h00);
    gap(8'h04);
    // frame content: standard inputs, then fast samples per mode
    acc(1'b0, 1'b1, `HSL_A_PORT_SEL, 8'h01);
    acc(1'b0, 1'b1, `HSL_A_LINK0_CFG, 8'h03);
    frame_chk(24'h0);
    @(posedge sys_clk_i);
    dgpio_in <= 4'hF; two_lane <= 1'b1;
    acc(1'b1, 1'b1, `HSL_A_PORT_SEL, 8'h02);
    acc(1'b1, 1'b1, `HSL_A_LINK0_CFG, 8'h03);
    for (k = 0; k < 5; k = k + 1) begin
      acc(1'b0, 1'b1, `HSL_A_FCC_CFG, 8'h04 - k[7:0]);
      frame_chk({3{PL[k*8 +: 8]}});
    end
    @(posedge sys_clk_i);
    two_lane <= 1'b0;
    frame_chk(24'h0);
    summarize;
  end
endmodule // hsl_gpio_ctrl_tb
